//--- tslc_far_end.sv
// Far-end terminal model: slot timing, tx capture, rx frames
`timescale 1ns/1ps
module tslc_far_end (
  input wire clk_sys_i, // Clock
  input wire rst_n_i, // Reset
  input wire fdl_tx_bit_i, // Bit from block
  input wire [5:0] rx_code_i, // Code to send
  input wire rx_go_i, // Send one frame
  output wire fdl_tx_slot_o, // Tx slot pulse
  output reg fdl_rx_slot_o, // Rx slot pulse
  output reg fdl_rx_bit_o, // Rx bit
  output wire rx_busy_o, // Frame in progress
  output reg [63:0] cap_o // Captured, newest at bit 0
);
  reg [1:0] div;
  reg [4:0] idx;
  // ones, zero, code LSB first, zero
  wire [15:0] frm = {1'b0, rx_code_i, 1'b0, 8'hFF};
  assign fdl_tx_slot_o = (div == 2'h1);
  assign rx_busy_o = !idx[4];
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div <= 2'h0;
      idx <= 5'h10;
      cap_o <= 64'h0;
      fdl_rx_slot_o <= 1'b0;
      fdl_rx_bit_o <= 1'b0;
    end else begin
      div <= div + 2'h1;
      if (fdl_tx_slot_o)
        cap_o <= {cap_o[62:0], fdl_tx_bit_i};
      if (rx_go_i)
        idx <= 5'h00;
      // Off-slot bit toggles so a stale value never looks valid
      if (div == 2'h3 && rx_busy_o && !rx_go_i) begin
        fdl_rx_slot_o <= 1'b1;
        fdl_rx_bit_o <= frm[idx[3:0]];
        idx <= idx + 5'h01;
      end else begin
        fdl_rx_slot_o <= 1'b0;
        fdl_rx_bit_o <= ~fdl_rx_bit_o;
      end
    end
  end
endmodule

//--- tslc_link_ctrl.v
// Link code controller: registers, code transmitter and code receiver
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "tslc_map.vh"
module tslc_link_ctrl #(
  parameter [7:0] PART_ID = 8'hA5  // Arbitrary identifier value
) (
  input wire clk_sys_i,            // System clock, 200 MHz
  input wire rst_n_i,              // Async reset, active low
  input wire [15:0] addr_i,        // Register address
  input wire [7:0] wr_data_i,      // Write data
  input wire wr_stb_i,             // Write strobe
  input wire rd_stb_i,             // Read strobe
  output reg [7:0] rd_data_o,      // Read data, cycle after strobe
  input wire fdl_tx_slot_i,        // Transmit data link bit slot
  output wire fdl_tx_bit_o,        // Transmit data link bit
  output wire tx_busy_o,           // Transmitter sending
  input wire fdl_rx_slot_i,        // Receive data link bit valid
  input wire fdl_rx_bit_i,         // Receive data link bit
  output reg rx_code_alarm_o,      // Qualified code received
  output reg [2:0] match_alarm_o   // Expected code matched
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CODE = 3'b010;
  localparam [2:0] ST_TAIL = 3'b100;

  reg tail_abort_enable;
  reg [1:0] match_qualify_filter;
  reg rx_code_enable;
  reg [1:0] rx_qualify_filter;
  reg [5:0] rx_latched_code;
  reg [5:0] expected_code [0:2];
  reg [5:0] tx_code_value;
  reg [7:0] tx_repeat_count;
  reg [2:0] tx_state;
  reg [15:0] tx_shift;
  reg [3:0] tx_bits;
  reg [7:0] tx_reps;
  reg [15:0] rx_shift;
  reg [3:0] rx_bits;
  reg rx_locked;
  reg rx_full;
  reg rx_evt;
  reg rx_err;
  reg [5:0] rx_code;
  reg [7:0] next_rd;

  wire wr_ctrl = wr_stb_i && addr_i == `TSLC_ADDR_CTRL;
  wire send_code_strobe = wr_ctrl && wr_data_i[`TSLC_BIT_SEND];
  wire code_logic_reset = wr_ctrl && wr_data_i[`TSLC_BIT_SOFT_RST];
  // sixteen-bit frame, sent from bit 0
  wire [15:0] tx_frame = {1'b0, tx_code_value, 1'b0, `TSLC_PREAMBLE};
  wire [7:0] tx_tail = tail_abort_enable ? `TSLC_ABORT_SEQ : `TSLC_IDLE_FLAG;
  // receive framing check, first bit in rx_shift[0]
  wire rx_pat_ok = rx_shift[7:0] == `TSLC_PREAMBLE && !rx_shift[8] &&
                   !rx_shift[15];
  wire rxq_qual;
  wire [5:0] rxq_code;
  wire mq_qual;
  wire [5:0] mq_code;

  assign fdl_tx_bit_o = tx_shift[0];
  assign tx_busy_o = tx_state != ST_IDLE;

  // Register writes
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tail_abort_enable <= 1'b0;
      match_qualify_filter <= 2'b00;
      rx_code_enable <= 1'b0;
      rx_qualify_filter <= 2'b00;
      expected_code[0] <= `TSLC_RST_CODE;
      expected_code[1] <= `TSLC_RST_CODE;
      expected_code[2] <= `TSLC_RST_CODE;
      tx_code_value <= `TSLC_RST_CODE;
      tx_repeat_count <= `TSLC_RST_REPEAT;
    end else if (code_logic_reset) begin
      tail_abort_enable <= 1'b0;
      match_qualify_filter <= 2'b00;
      rx_code_enable <= 1'b0;
      rx_qualify_filter <= 2'b00;
      expected_code[0] <= `TSLC_RST_CODE;
      expected_code[1] <= `TSLC_RST_CODE;
      expected_code[2] <= `TSLC_RST_CODE;
      tx_code_value <= `TSLC_RST_CODE;
      tx_repeat_count <= `TSLC_RST_REPEAT;
    end else if (wr_stb_i) begin
      case (addr_i)
        `TSLC_ADDR_CTRL: begin
          tail_abort_enable <= wr_data_i[`TSLC_BIT_ABORT];
          match_qualify_filter <=
            wr_data_i[`TSLC_BIT_MF_HI:`TSLC_BIT_MF_LO];
          rx_code_enable <= wr_data_i[`TSLC_BIT_RX_EN];
          rx_qualify_filter <=
            wr_data_i[`TSLC_BIT_RXF_HI:`TSLC_BIT_RXF_LO];
        end
        `TSLC_ADDR_EXP_ONE: expected_code[0] <= wr_data_i[`TSLC_CODE_HI:0];
        `TSLC_ADDR_EXP_TWO: expected_code[1] <= wr_data_i[`TSLC_CODE_HI:0];
        `TSLC_ADDR_EXP_THREE:
          expected_code[2] <= wr_data_i[`TSLC_CODE_HI:0];
        `TSLC_ADDR_TX_CODE: tx_code_value <= wr_data_i[`TSLC_CODE_HI:0];
        `TSLC_ADDR_REPEAT: tx_repeat_count <= wr_data_i;
        default: ;
      endcase
    end
  end

  // Read mux; self-clearing bits always read zero
  always @* begin
    case (addr_i)
      `TSLC_ADDR_CTRL: next_rd = {tail_abort_enable, match_qualify_filter,
                                  rx_code_enable, 1'b0, rx_qualify_filter,
                                  1'b0};
      `TSLC_ADDR_RX_CODE: next_rd = {2'b00, rx_latched_code};
      `TSLC_ADDR_EXP_ONE: next_rd = {2'b00, expected_code[0]};
      `TSLC_ADDR_EXP_TWO: next_rd = {2'b00, expected_code[1]};
      `TSLC_ADDR_EXP_THREE: next_rd = {2'b00, expected_code[2]};
      `TSLC_ADDR_TX_CODE: next_rd = {2'b00, tx_code_value};
      `TSLC_ADDR_REPEAT: next_rd = tx_repeat_count;
      `TSLC_ADDR_PART_ID: next_rd = PART_ID;
      default: next_rd = 8'h00;
    endcase
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i)
      rd_data_o <= 8'h00;
    else if (rd_stb_i)
      rd_data_o <= next_rd;
    else
      rd_data_o <= 8'h00;
  end

  // Transmitter; a new send restarts with the current count
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_state <= ST_IDLE;
      tx_shift <= 16'hFFFF;
      tx_bits <= 4'h0;
      tx_reps <= 8'h00;
    end else if (code_logic_reset) begin
      tx_state <= ST_IDLE;
      tx_shift <= 16'hFFFF;
      tx_bits <= 4'h0;
      tx_reps <= 8'h00;
    end else if (send_code_strobe) begin
      // restart picks up a new count
      tx_state <= ST_CODE;
      tx_shift <= tx_frame;
      tx_bits <= 4'h0;
      tx_reps <= tx_repeat_count;
    end else if (fdl_tx_slot_i) begin
      case (tx_state)
        ST_CODE: begin
          tx_bits <= tx_bits + 4'h1;
          tx_shift <= {1'b1, tx_shift[15:1]};
          if (tx_bits == `TSLC_FRAME_LAST) begin
            if (tx_reps == 8'h00) begin
              tx_shift <= tx_frame;
            end else if (tx_reps == 8'h01) begin
              tx_state <= ST_TAIL;
              tx_shift <= {8'hFF, tx_tail};
            end else begin
              tx_reps <= tx_reps - 8'h01;
              tx_shift <= tx_frame;
            end
          end
        end
        ST_TAIL: begin
          tx_bits <= tx_bits + 4'h1;
          tx_shift <= {1'b1, tx_shift[15:1]};
          if (tx_bits == `TSLC_TAIL_LAST) begin
            tx_state <= ST_IDLE;
            tx_shift <= 16'hFFFF;
            tx_bits <= 4'h0;
          end
        end
        ST_IDLE: tx_shift <= 16'hFFFF;
        default: begin
          tx_state <= ST_IDLE;
          tx_shift <= 16'hFFFF;
        end
      endcase
    end
  end

  // Receive pattern detector; sliding search, then one look per 16 bits
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_shift <= 16'h0000;
      rx_bits <= 4'h0;
      rx_locked <= 1'b0;
      rx_full <= 1'b0;
      rx_evt <= 1'b0;
      rx_err <= 1'b0;
      rx_code <= `TSLC_RST_CODE;
    end else if (code_logic_reset || !rx_code_enable) begin
      rx_shift <= 16'h0000;
      rx_bits <= 4'h0;
      rx_locked <= 1'b0;
      rx_full <= 1'b0;
      rx_evt <= 1'b0;
      rx_err <= 1'b0;
    end else begin
      rx_evt <= 1'b0;
      rx_err <= 1'b0;
      rx_full <= 1'b0;
      if (fdl_rx_slot_i) begin
        rx_shift <= {fdl_rx_bit_i, rx_shift[15:1]};
        rx_bits <= rx_bits + 4'h1;
        // Sixteen fresh bits since the last look
        rx_full <= rx_locked && rx_bits == 4'hF;
      end
      if (!rx_locked && rx_pat_ok) begin
        rx_evt <= 1'b1;
        rx_code <= rx_shift[14:9];
        rx_locked <= 1'b1;
        rx_bits <= fdl_rx_slot_i ? 4'h1 : 4'h0;
      end else if (rx_full && rx_pat_ok) begin
        // Each frame counted once; a stale window would count twice
        rx_evt <= 1'b1;
        rx_code <= rx_shift[14:9];
      end else if (rx_full) begin
        // Broken pattern ends the run
        rx_err <= 1'b1;
        rx_locked <= 1'b0;
      end
    end
  end

  tslc_qualify u_rx_filter (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .clear_i(code_logic_reset || !rx_code_enable),
    .evt_i(rx_evt),
    .err_i(rx_err),
    .code_i(rx_code),
    .setting_i(rx_qualify_filter),
    .qual_o(rxq_qual),
    .code_o(rxq_code)
  );

  tslc_qualify u_match_filter (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .clear_i(code_logic_reset || !rx_code_enable),
    .evt_i(rx_evt),
    .err_i(rx_err),
    .code_i(rx_code),
    .setting_i(match_qualify_filter),
    .qual_o(mq_qual),
    .code_o(mq_code)
  );

  // Latched code and alarms
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_latched_code <= `TSLC_RST_CODE;
      rx_code_alarm_o <= 1'b0;
    end else if (code_logic_reset) begin
      rx_latched_code <= `TSLC_RST_CODE;
      rx_code_alarm_o <= 1'b0;
    end else if (rxq_qual) begin
      rx_latched_code <= rxq_code;
      rx_code_alarm_o <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_match
      always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
          match_alarm_o[gi] <= 1'b0;
        else if (code_logic_reset)
          match_alarm_o[gi] <= 1'b0;
        else if (mq_qual)
          match_alarm_o[gi] <= mq_code == expected_code[gi];
      end
    end
  endgenerate
endmodule

//--- tslc_link_ctrl_asserts.sv
// Port checker for the link code controller
`timescale 1ns/1ps
`include "tslc_map.vh"
module tslc_link_ctrl_asserts #(
  parameter [7:0] PART_ID = 8'hA5 // Arbitrary identifier value
) (
  input wire clk_sys_i, // Clock
  input wire rst_n_i, // Reset
  input wire [15:0] addr_i, // Address
  input wire [7:0] wr_data_i, // Write data
  input wire wr_stb_i, // Write strobe
  input wire rd_stb_i, // Read strobe
  input wire [7:0] rd_data_o, // Read data
  input wire fdl_tx_slot_i, // Tx slot
  input wire fdl_tx_bit_o, // Tx bit
  input wire tx_busy_o, // Tx busy
  input wire fdl_rx_slot_i, // Rx slot
  input wire fdl_rx_bit_i, // Rx bit
  input wire rx_code_alarm_o, // Rx alarm
  input wire [2:0] match_alarm_o // Match alarms
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  wire ctl_wr = wr_stb_i && addr_i == `TSLC_ADDR_CTRL;
  wire ctl_rd = rd_stb_i && addr_i == `TSLC_ADDR_CTRL;
  wire id_rd = rd_stb_i && addr_i == `TSLC_ADDR_PART_ID;
  wire rxc_rd = rd_stb_i && addr_i == `TSLC_ADDR_RX_CODE;
  // Expected codes and transmit code sit at consecutive offsets
  wire code_rd = rd_stb_i && addr_i >= `TSLC_ADDR_EXP_ONE &&
    addr_i <= `TSLC_ADDR_TX_CODE;
  part_id_a: assert property (id_rd |=> rd_data_o == PART_ID)
    else $error("identifier read wrong");
  rx_code_top_a: assert property (rxc_rd |=>
    rd_data_o[7:6] == 2'h0) else $error("rx code top bits set");
  code_top_a: assert property (code_rd |=>
    rd_data_o[7:6] == 2'h0) else $error("code register top bits set");
  self_clear_a: assert property (ctl_rd |=>
    !rd_data_o[0] && !rd_data_o[3]) else $error("control bit stuck");
  send_start_a: assert property (ctl_wr && wr_data_i[0] &&
    !wr_data_i[3] |=> tx_busy_o) else $error("send did not start");
  soft_clear_a: assert property (ctl_wr && wr_data_i[3] |=>
    !tx_busy_o && !rx_code_alarm_o && match_alarm_o == 3'h0)
    else $error("soft reset left state");
  busy_hold_a: assert property (tx_busy_o && !fdl_tx_slot_i &&
    !wr_stb_i |=> tx_busy_o) else $error("busy fell off slot");
  bit_hold_a: assert property (!fdl_tx_slot_i && !wr_stb_i |=>
    $stable(fdl_tx_bit_o)) else $error("tx bit moved off slot");
  idle_one_a: assert property (!tx_busy_o |-> fdl_tx_bit_o)
    else $error("idle line not one");
  alarm_keep_a: assert property (rx_code_alarm_o && !wr_stb_i |=>
    rx_code_alarm_o) else $error("rx alarm self cleared");
  cover property ($rose(tx_busy_o));
  cover property ($rose(rx_code_alarm_o));
  cover property (match_alarm_o == 3'h3);
endmodule
bind tslc_link_ctrl tslc_link_ctrl_asserts #(.PART_ID(PART_ID)) u_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
  .rd_data_o(rd_data_o), .fdl_tx_slot_i(fdl_tx_slot_i),
  .fdl_tx_bit_o(fdl_tx_bit_o), .tx_busy_o(tx_busy_o),
  .fdl_rx_slot_i(fdl_rx_slot_i), .fdl_rx_bit_i(fdl_rx_bit_i),
  .rx_code_alarm_o(rx_code_alarm_o), .match_alarm_o(match_alarm_o));

//--- tslc_link_ctrl_tb.sv
// Testbench for the link code controller
`timescale 1ns/1ps
`include "tslc_map.vh"
module tslc_link_ctrl_tb;
  localparam [7:0] ID_VAL = 8'h5A; // Arbitrary identifier value
  reg clk_sys_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [15:0] addr_i = 16'h0000;
  reg [7:0] wr_data_i = 8'h00;
  reg wr_stb_i = 1'b0;
  reg rd_stb_i = 1'b0;
  reg rx_go = 1'b0;
  wire [7:0] rd_data_o;
  wire tx_slot, tx_bit, tx_busy, rx_slot, rx_bit, rx_busy, rx_alarm;
  wire [2:0] m_alarm;
  wire [63:0] cap;
  wire [15:0] tx_frm = {1'b0, 6'h04, 1'b0, 8'hFF};
  integer num_errors = 0;
  integer n_tests = 0;
  integer f, k;
  reg [7:0] d;
  reg [63:0] exp;
  reg [39:0] rows [0:8]; // Address, reset, write, read back
  always #2.5 clk_sys_i = ~clk_sys_i;
  tslc_link_ctrl #(.PART_ID(ID_VAL)) uut (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rd_data_o(rd_data_o),
    .fdl_tx_slot_i(tx_slot), .fdl_tx_bit_o(tx_bit), .tx_busy_o(tx_busy),
    .fdl_rx_slot_i(rx_slot), .fdl_rx_bit_i(rx_bit),
    .rx_code_alarm_o(rx_alarm), .match_alarm_o(m_alarm));
  tslc_far_end far (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .fdl_tx_bit_i(tx_bit), .rx_code_i(6'h0C), .rx_go_i(rx_go),
    .fdl_tx_slot_o(tx_slot), .fdl_rx_slot_o(rx_slot),
    .fdl_rx_bit_o(rx_bit), .rx_busy_o(rx_busy), .cap_o(cap));
  task give_verdict;
    begin
      $display("Checks %0d, errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk8(input [7:0] got, input [7:0] want);
    begin
      n_tests = n_tests + 1;
      if (got !== want) begin
        num_errors = num_errors + 1;
        $display("Error at %0t: got %h want %h", $time, got, want);
      end
    end
  endtask
  task chk64(input [63:0] got, input [63:0] want);
    begin
      n_tests = n_tests + 1;
      if (got !== want) begin
        num_errors = num_errors + 1;
        $display("Error at %0t: got %h want %h", $time, got, want);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] v);
    begin
      @(posedge clk_sys_i);
      addr_i <= a;
      wr_data_i <= v;
      wr_stb_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_stb_i <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, output [7:0] v);
    begin
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_stb_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_stb_i <= 1'b0;
      #1;
      v = rd_data_o;
    end
  endtask
  // Bounded wait for both link directions to go quiet
  task wait_idle;
    integer i;
    begin
      i = 0;
      do begin
        @(posedge clk_sys_i);
        #1;
        i = i + 1;
      end while ((tx_busy !== 1'b0 || rx_busy !== 1'b0) && i < 3000);
      if (i >= 3000) begin
        num_errors = num_errors + 1;
        give_verdict;
      end
    end
  endtask
  task send(input [7:0] reps, input [7:0] ctl, input [7:0] tail);
    integer r, b;
    begin
      wr(`TSLC_ADDR_REPEAT, reps);
      wr(`TSLC_ADDR_CTRL, ctl);
      wait_idle;
      exp = 64'h0;
      for (r = 0; r < reps; r = r + 1)
        for (b = 0; b < 16; b = b + 1)
          exp = {exp[62:0], tx_frm[b]};
      for (b = 0; b < 8; b = b + 1)
        exp = {exp[62:0], tail[b]};
      exp = exp ^ cap;
      chk64(exp & ((64'h1 << (reps * 16 + 8)) - 64'h1), 64'h0);
    end
  endtask
  task rx_frame;
    begin
      @(posedge clk_sys_i);
      rx_go <= 1'b1;
      @(posedge clk_sys_i);
      rx_go <= 1'b0;
      wait_idle;
      repeat (6) @(posedge clk_sys_i);
      #1;
    end
  endtask
  task chk_defaults;
    integer r;
    begin
      for (r = 0; r < 9; r = r + 1) begin
        rd(rows[r][39:24], d);
        chk8(d, rows[r][31:24] == 8'hFE ? ID_VAL : rows[r][23:16]);
      end
    end
  endtask
  initial begin
    rows[0] = {16'h0172, 8'h00, 8'hFF, 8'h3F};
    rows[1] = {16'h0173, 8'h00, 8'h2A, 8'h2A};
    rows[2] = {16'h0174, 8'h00, 8'hC5, 8'h05};
    rows[3] = {16'h0175, 8'h00, 8'hC4, 8'h04};
    rows[4] = {16'h0176, 8'h01, 8'h03, 8'h03};
    rows[5] = {16'h0171, 8'h00, 8'h3F, 8'h00};
    rows[6] = {16'h01FE, 8'h00, 8'h00, ID_VAL};
    rows[7] = {16'h0100, 8'h00, 8'h77, 8'h00};
    rows[8] = {16'h0170, 8'h00, 8'h80, 8'h80};
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    chk_defaults;
    for (k = 0; k < 9; k = k + 1) begin
      wr(rows[k][39:24], rows[k][15:8]);
      rd(rows[k][39:24], d);
      chk8(d, rows[k][7:0]);
    end
    send(8'h02, 8'h01, `TSLC_IDLE_FLAG);
    send(8'h01, 8'h81, `TSLC_ABORT_SEQ);
    rd(`TSLC_ADDR_CTRL, d);
    chk8(d, 8'h80);
    wr(`TSLC_ADDR_REPEAT, 8'h00);
    wr(`TSLC_ADDR_CTRL, 8'h01);
    repeat (1000) @(posedge clk_sys_i);
    #1;
    chk8({7'h00, tx_busy}, 8'h01);
    send(8'h01, 8'h01, `TSLC_IDLE_FLAG);
    wr(`TSLC_ADDR_EXP_ONE, 8'h0C);
    wr(`TSLC_ADDR_CTRL, 8'h00);
    rx_frame;
    chk8({4'h0, m_alarm, rx_alarm}, 8'h00);
    for (f = 0; f < 4; f = f + 1) begin
      wr(`TSLC_ADDR_CTRL, 8'h08);
      wr(`TSLC_ADDR_EXP_ONE, 8'h0C);
      wr(`TSLC_ADDR_EXP_TWO, 8'h0C);
      wr(`TSLC_ADDR_EXP_THREE, 8'h30);
      wr(`TSLC_ADDR_CTRL, {1'b0, 2'(3 - f), 1'b1, 1'b0, 2'(f), 1'b0});
      for (k = 1; k <= 7; k = k + 1) begin
        rx_frame;
        chk8({7'h00, rx_alarm}, {7'h00, k >= 2 * f + 1});
        chk8({5'h00, m_alarm}, k >= 7 - 2 * f ? 8'h03 : 8'h00);
      end
      rd(`TSLC_ADDR_RX_CODE, d);
      chk8(d, 8'h0C);
    end
    wr(`TSLC_ADDR_CTRL, 8'h08);
    chk_defaults;
    give_verdict;
  end
endmodule

//--- tslc_map.vh
// Register map and code framing constants for the link code controller
`ifndef TSLC_MAP_VH
`define TSLC_MAP_VH
`define TSLC_ADDR_CTRL 16'h0170
`define TSLC_ADDR_RX_CODE 16'h0171
`define TSLC_ADDR_EXP_ONE 16'h0172
`define TSLC_ADDR_EXP_TWO 16'h0173
`define TSLC_ADDR_EXP_THREE 16'h0174
`define TSLC_ADDR_TX_CODE 16'h0175
`define TSLC_ADDR_REPEAT 16'h0176
`define TSLC_ADDR_PART_ID 16'h01FE
`define TSLC_RST_CTRL 8'h00
`define TSLC_RST_CODE 6'h00
`define TSLC_RST_REPEAT 8'h01
`define TSLC_BIT_SEND 0
`define TSLC_BIT_RXF_LO 1
`define TSLC_BIT_RXF_HI 2
`define TSLC_BIT_SOFT_RST 3
`define TSLC_BIT_RX_EN 4
`define TSLC_BIT_MF_LO 5
`define TSLC_BIT_MF_HI 6
`define TSLC_BIT_ABORT 7
`define TSLC_CODE_HI 5
`define TSLC_PREAMBLE 8'hFF
`define TSLC_IDLE_FLAG 8'h7E
`define TSLC_ABORT_SEQ 8'hFF
`define TSLC_FRAME_LAST 4'hF
`define TSLC_TAIL_LAST 4'h7
`define TSLC_NEED_NONE 3'h1
`define TSLC_NEED_THREE 3'h3
`define TSLC_NEED_FIVE 3'h5
`define TSLC_NEED_SEVEN 3'h7
`endif

//--- tslc_qualify.v
// Consecutive identical code qualification filter
`timescale 1ns/1ps
`include "tslc_map.vh"
module tslc_qualify (
  input wire clk_sys_i,        // System clock
  input wire rst_n_i,          // Async reset, active low
  input wire clear_i,          // Synchronous clear
  input wire evt_i,            // Error-free code seen
  input wire err_i,            // Pattern broken
  input wire [5:0] code_i,     // Code with evt_i
  input wire [1:0] setting_i,  // Filter setting
  output reg qual_o,           // Qualified pulse
  output reg [5:0] code_o      // Qualified code
);
  reg [2:0] run;
  reg [5:0] last;
  reg [2:0] need;
  reg [2:0] next_run;

  always @* begin
    case (setting_i)
      2'b01: need = `TSLC_NEED_THREE;
      2'b10: need = `TSLC_NEED_FIVE;
      2'b11: need = `TSLC_NEED_SEVEN;
      default: need = `TSLC_NEED_NONE;
    endcase
    if (evt_i && code_i == last && run != 3'h0 && run != 3'h7)
      next_run = run + 3'h1;
    else if (evt_i && code_i == last && run == 3'h7)
      next_run = run;
    else
      next_run = 3'h1;
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run <= 3'h0;
      last <= `TSLC_RST_CODE;
      qual_o <= 1'b0;
      code_o <= `TSLC_RST_CODE;
    end else if (clear_i) begin
      run <= 3'h0;
      last <= `TSLC_RST_CODE;
      qual_o <= 1'b0;
      code_o <= `TSLC_RST_CODE;
    end else begin
      qual_o <= 1'b0;
      if (err_i) begin
        run <= 3'h0;
      end else if (evt_i) begin
        run <= next_run;
        last <= code_i;
        // Fires on the count that meets the setting; once per run for settings 0-2, on every further repeat at seven once run saturates
        if (next_run == need) begin
          qual_o <= 1'b1;
          code_o <= code_i;
        end
      end
    end
  end
endmodule
